// ==== rwp_defs.svh ====
// Constants for the write-protect and flag block: offsets, bits, resets, timing
`ifndef RWP_DEFS_SVH
`define RWP_DEFS_SVH

// Clock rate and timing figures
`define RWP_CLK_MHZ       25
`define RWP_REARM_US      62
`define RWP_CSUP_MS       2
`define RWP_HOLD_MS       11
`define RWP_REARM_CYC     (`RWP_REARM_US * `RWP_CLK_MHZ)
`define RWP_CSUP_CYC      (`RWP_CSUP_MS * 1000 * `RWP_CLK_MHZ)
`define RWP_HOLD_CYC      (`RWP_HOLD_MS * 1000 * `RWP_CLK_MHZ)
`define RWP_CNT_W         20

// Register offsets (storage occupies 4'h0 to 4'h7)
`define RWP_ADR_STORE_TOP 4'h7
`define RWP_ADR_CTRL_D    4'h8
`define RWP_ADR_CTRL_E    4'h9
`define RWP_ADR_CTRL_F    4'ha
`define RWP_ADR_PERIOD    4'hb

// Field positions of CTRL_D
`define RWP_D_MASK_P      0
`define RWP_D_MASK_A      1
`define RWP_D_LPS_P       2
`define RWP_D_LPS_A       3
// Field positions of CTRL_E
`define RWP_E_WP          0
`define RWP_E_PFLAG       1
`define RWP_E_AFLAG       2
`define RWP_E_RFLAG       3
// Field positions of CTRL_F
`define RWP_F_BANK        0
`define RWP_F_TEST0       1
`define RWP_F_TEST1       2

// Interval select that follows each seconds carry
`define RWP_SEL_SEC_CARRY 3'h5

// Reset values
`define RWP_WP_RST        1'b1
`define RWP_NIB_RST       4'h0
`define RWP_SEL_RST       3'h0

`endif

// ==== rwp_pkg.sv ====
// Types for the write-protect and flag block
package rwp_pkg;
  `include "rwp_defs.svh"

  // One host access on the nibble bus
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [3:0] addr;
    logic [3:0] data;
  } rwp_req_s;

  // Whole state of the main module
  typedef struct packed {
    logic [7:0][3:0]       store;
    logic                  mask_p;
    logic                  mask_a;
    logic                  lps_p;
    logic                  lps_a;
    logic [2:0]            period_sel;
    logic                  wp;
    logic                  pflag;
    logic                  aflag;
    logic                  rflag;
    logic                  bank;
    logic [1:0]            test;
    logic                  clr_pend;
    logic [`RWP_CNT_W-1:0] cs_cnt;
    logic [`RWP_CNT_W-1:0] hold_cnt;
    logic [`RWP_CNT_W-1:0] rearm_cnt;
    logic [3:0]            rdata;
    logic                  irq;
  } rwp_state_s;

  // State of the pin synchroniser
  typedef struct packed {
    logic [2:0] chain;
    logic       level;
  } rwp_sync_s;
endpackage

// ==== rwp_sync.sv ====
// Three-stage synchroniser that accepts a change once stages two and three agree
`timescale 1ns/1ps
module rwp_sync (
  input  wire logic clk_in,     // System clock
  input  wire logic sys_rst_in, // Synchronous reset, high
  input  wire logic pin_in,     // Asynchronous pin
  output logic      level_out   // Filtered level
);
  import rwp_pkg::*;

  rwp_sync_s st_ff;
  rwp_sync_s nxt_st;

  // Shift chain; stage one feeds only stage two
  always_comb begin
    nxt_st       = st_ff;
    nxt_st.chain = {st_ff.chain[1:0], pin_in};
    if (st_ff.chain[1] == st_ff.chain[2]) begin
      nxt_st.level = st_ff.chain[2];
    end
  end

  // State register
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign level_out = st_ff.level;
endmodule // rwp_sync

// ==== rwp_top.sv ====
// Write protect, flag side effects and interrupt combine for the clock block
`timescale 1ns/1ps
`include "rwp_defs.svh"

// Functional notes
// RULE_01: Host clears protection before other writes.
// RULE_02: Bank select bit writable at any time.
// RULE_03: Re-arm protection only 62 us after clear.
// RULE_04: Level-mode event flags clear after read one.
// RULE_05: Read-tracking flag clears after read one.
// RULE_06: Test bits reset on read, read zero.
// RULE_07: Interrupt pin ORs masked periodic and alarm.
// RULE_08: Host programs event settings while unprotected.
// RULE_09: Interval select 101 fires every seconds carry.
// RULE_10: Storage and control bits limited only by protection.
// RULE_11: Host avoids half-minute round during time writes.
// RULE_12: All registers readable anytime; side effects on flags and test bits only.
// RULE_13: Unprotect needs 2 ms high then 11 ms held.
// RULE_14: Protect sets at once unless select low or early.
// RULE_15: Protected bits ignore writes while protection set.
module rwp_top #(
  parameter int CSUP_CYC  = `RWP_CSUP_CYC,  // Select-high settle before clear
  parameter int HOLD_CYC  = `RWP_HOLD_CYC,  // Select-high hold after clear
  parameter int REARM_CYC = `RWP_REARM_CYC  // Lockout before re-arming
) (
  input  wire logic             clk_in,              // 25 MHz clock
  input  wire logic             sys_rst_in,          // Synchronous reset, high
  input  wire rwp_pkg::rwp_req_s req_in,             // Host access
  input  wire logic             chip_select_high_in, // Asynchronous select pin
  input  wire logic             sec_carry_in,        // Seconds carry pulse
  input  wire logic [7:0]       period_tick_in,      // Interval tick pulses
  input  wire logic             alarm_match_in,      // Alarm match pulse
  output logic [3:0]            rdata_out,           // Read data, one cycle late
  output logic                  write_protect_out,   // Protection state
  output logic                  periodic_event_flag_out, // Periodic flag
  output logic                  alarm_event_flag_out,    // Alarm flag
  output logic                  bank_out,            // Bank select
  output logic                  interrupt_out        // Combined interrupt
);
  import rwp_pkg::*;

  rwp_state_s st_ff;
  rwp_state_s nxt_st;
  logic       cs_high;
  logic       wr_ok;
  logic       rearm_ok;
  logic       p_evt;
  logic       wr_e;
  logic       rd_e;
  logic       rd_f;

  // Select pin passes the synchroniser
  rwp_sync u_cs_sync (
    .clk_in     (clk_in),
    .sys_rst_in (sys_rst_in),
    .pin_in     (chip_select_high_in),
    .level_out  (cs_high)
  );

  // Decode helpers
  always_comb begin
    wr_ok    = req_in.wr && !st_ff.wp;                             // [RULE_15]
    rearm_ok = st_ff.rearm_cnt >= `RWP_CNT_W'(REARM_CYC);          // [RULE_03]
    wr_e     = req_in.wr && (req_in.addr == `RWP_ADR_CTRL_E);
    rd_e     = req_in.rd && (req_in.addr == `RWP_ADR_CTRL_E);
    rd_f     = req_in.rd && (req_in.addr == `RWP_ADR_CTRL_F);
    if (st_ff.period_sel == `RWP_SEL_SEC_CARRY) begin
      p_evt = sec_carry_in;                                        // [RULE_09]
    end else begin
      p_evt = period_tick_in[st_ff.period_sel];
    end
  end

  // Next state
  always_comb begin
    nxt_st = st_ff;

    // Select-high dwell counter, saturating
    if (!cs_high) begin
      nxt_st.cs_cnt = '0;
    end else if (st_ff.cs_cnt < `RWP_CNT_W'(CSUP_CYC)) begin
      nxt_st.cs_cnt = st_ff.cs_cnt + 1'b1;
    end
    if (!rearm_ok) begin
      nxt_st.rearm_cnt = st_ff.rearm_cnt + 1'b1;
    end

    // Storage and control writes, only while unprotected
    if (wr_ok) begin
      if (req_in.addr <= `RWP_ADR_STORE_TOP) begin
        nxt_st.store[req_in.addr[2:0]] = req_in.data;              // [RULE_10]
      end
      case (req_in.addr)
        `RWP_ADR_CTRL_D: begin
          nxt_st.mask_p = req_in.data[`RWP_D_MASK_P];              // [RULE_10]
          nxt_st.mask_a = req_in.data[`RWP_D_MASK_A];
          nxt_st.lps_p  = req_in.data[`RWP_D_LPS_P];
          nxt_st.lps_a  = req_in.data[`RWP_D_LPS_A];
        end
        `RWP_ADR_CTRL_E: begin
          // Writing zero clears a flag; writing one leaves it
          if (!req_in.data[`RWP_E_PFLAG]) nxt_st.pflag = 1'b0;
          if (!req_in.data[`RWP_E_AFLAG]) nxt_st.aflag = 1'b0;
          if (!req_in.data[`RWP_E_RFLAG]) nxt_st.rflag = 1'b0;
        end
        `RWP_ADR_CTRL_F: begin
          nxt_st.test = {req_in.data[`RWP_F_TEST1],
                         req_in.data[`RWP_F_TEST0]};
        end
        `RWP_ADR_PERIOD: begin
          nxt_st.period_sel = req_in.data[2:0];
        end
        default: begin
        end
      endcase
    end

    // Bank select ignores protection
    if (req_in.wr && (req_in.addr == `RWP_ADR_CTRL_F)) begin
      nxt_st.bank = req_in.data[`RWP_F_BANK];                      // [RULE_02]
    end

    // Read data and read side effects
    case (req_in.addr)
      `RWP_ADR_CTRL_D: begin
        nxt_st.rdata = {st_ff.lps_a, st_ff.lps_p,
                        st_ff.mask_a, st_ff.mask_p};
      end
      `RWP_ADR_CTRL_E: begin
        nxt_st.rdata = {st_ff.rflag, st_ff.aflag,
                        st_ff.pflag, st_ff.wp};
      end
      `RWP_ADR_CTRL_F: begin
        nxt_st.rdata = {3'h0, st_ff.bank};                         // [RULE_06]
      end
      `RWP_ADR_PERIOD: begin
        nxt_st.rdata = {1'b0, st_ff.period_sel};
      end
      default: begin
        if (req_in.addr <= `RWP_ADR_STORE_TOP) begin
          nxt_st.rdata = st_ff.store[req_in.addr[2:0]];            // [RULE_12]
        end else begin
          nxt_st.rdata = 4'h0;
        end
      end
    endcase
    if (!req_in.rd) begin
      nxt_st.rdata = st_ff.rdata;
    end
    if (rd_f) begin
      nxt_st.test = 2'h0;                                          // [RULE_06]
    end
    if (rd_e && st_ff.pflag && st_ff.lps_p) begin
      nxt_st.pflag = 1'b0;                                         // [RULE_04]
    end
    if (rd_e && st_ff.aflag && st_ff.lps_a) begin
      nxt_st.aflag = 1'b0;                                         // [RULE_04]
    end
    if (rd_e && st_ff.rflag) begin
      nxt_st.rflag = 1'b0;                                         // [RULE_05]
    end

    // Events: sticky in level mode, one-cycle pulse otherwise; set wins
    if (st_ff.lps_p) begin
      if (p_evt) nxt_st.pflag = 1'b1;
    end else begin
      nxt_st.pflag = p_evt;
    end
    if (st_ff.lps_a) begin
      if (alarm_match_in) nxt_st.aflag = 1'b1;
    end else begin
      nxt_st.aflag = alarm_match_in;
    end
    if (sec_carry_in) begin
      nxt_st.rflag = 1'b1;
    end

    // Protection clear sequence
    if (st_ff.clr_pend) begin
      if (!cs_high) begin
        nxt_st.clr_pend = 1'b0;                                    // [RULE_13]
      end else if (st_ff.hold_cnt >= `RWP_CNT_W'(HOLD_CYC - 1)) begin
        nxt_st.clr_pend  = 1'b0;                                   // [RULE_13]
        nxt_st.wp        = 1'b0;
        nxt_st.rearm_cnt = '0;                                     // [RULE_03]
      end else begin
        nxt_st.hold_cnt = st_ff.hold_cnt + 1'b1;
      end
    end
    if (wr_e && !req_in.data[`RWP_E_WP] && st_ff.wp && !st_ff.clr_pend &&
        cs_high && (st_ff.cs_cnt >= `RWP_CNT_W'(CSUP_CYC))) begin
      nxt_st.clr_pend = 1'b1;                                      // [RULE_13]
      nxt_st.hold_cnt = '0;
    end
    if (wr_e && req_in.data[`RWP_E_WP] && cs_high && rearm_ok) begin
      nxt_st.wp       = 1'b1;                                      // [RULE_14]
      nxt_st.clr_pend = 1'b0;
    end

    // Combined interrupt from next flags
    nxt_st.irq = (nxt_st.pflag && !nxt_st.mask_p) ||
                 (nxt_st.aflag && !nxt_st.mask_a);                 // [RULE_07]
  end

  // State register
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      st_ff            <= '0;
      st_ff.wp         <= `RWP_WP_RST;
      st_ff.period_sel <= `RWP_SEL_RST;
      st_ff.rdata      <= `RWP_NIB_RST;
      st_ff.rearm_cnt  <= `RWP_CNT_W'(REARM_CYC);
    end else begin
      st_ff <= nxt_st;
    end
  end

  // Outputs straight from the state register
  assign rdata_out               = st_ff.rdata;
  assign write_protect_out       = st_ff.wp;
  assign periodic_event_flag_out = st_ff.pflag;
  assign alarm_event_flag_out    = st_ff.aflag;
  assign bank_out                = st_ff.bank;
  assign interrupt_out           = st_ff.irq;
endmodule // rwp_top

// ==== rwp_top_properties.sv ====
// Checker for the write-protect and flag block
`timescale 1ns/1ps
module rwp_chk #(
  parameter int REARM_CYC = 10 // Lockout cycles
) (
  input wire logic              clk_in,                  // Clock
  input wire logic              sys_rst_in,              // Reset
  input wire rwp_pkg::rwp_req_s req_in,                  // Access
  input wire logic              chip_select_high_in,     // Select pin
  input wire logic              alarm_match_in,          // Alarm pulse
  input wire logic [3:0]        rdata_out,               // Read data
  input wire logic              write_protect_out,       // Protection
  input wire logic              periodic_event_flag_out, // Periodic
  input wire logic              alarm_event_flag_out,    // Alarm
  input wire logic              bank_out,                // Bank
  input wire logic              interrupt_out            // Interrupt
);
  import rwp_pkg::*;
  default clocking @(posedge clk_in); endclocking
  default disable iff (sys_rst_in);
  logic [15:0] since_ff;
  logic [7:0]  cs_ff;
  // Cycles since protection was seen low, and select seen high
  always_ff @(posedge clk_in) begin
    if (sys_rst_in || write_protect_out) since_ff <= 16'h0;
    else if (since_ff != 16'hffff) since_ff <= since_ff + 16'h1;
    if (sys_rst_in || !chip_select_high_in) cs_ff <= 8'h0;
    else if (cs_ff != 8'hff) cs_ff <= cs_ff + 8'h1;
  end
  property p_bank;
    req_in.wr && req_in.addr == 4'ha |=> bank_out == $past(req_in.data[0]);
  endproperty
  a_bank: assert property (p_bank) else $error("bank not written");
  property p_rd_e;
    req_in.rd && !req_in.wr && req_in.addr == 4'h9 |=>
      rdata_out[0] == $past(write_protect_out) &&
      rdata_out[2] == $past(alarm_event_flag_out);
  endproperty
  a_rd_e: assert property (p_rd_e) else $error("bad status read");
  property p_test;
    req_in.rd && req_in.addr == 4'ha |=> rdata_out[3:1] == 3'h0;
  endproperty
  a_test: assert property (p_test) else $error("test bits read");
  property p_unmap;
    req_in.rd && req_in.addr[3:2] == 2'h3 |=> rdata_out == 4'h0;
  endproperty
  a_unmap: assert property (p_unmap) else $error("unmapped read");
  property p_cs_low;
    !chip_select_high_in [*6] |=> !$fell(write_protect_out);
  endproperty
  a_cs_low: assert property (p_cs_low) else $error("clear, select low");
  property p_set;
    req_in.wr && req_in.addr == 4'h9 && req_in.data[0] && cs_ff >= 8'h8 &&
      since_ff >= 16'(REARM_CYC + 2) |=> write_protect_out;
  endproperty
  a_set: assert property (p_set) else $error("protect not set");
  property p_lock;
    req_in.wr && req_in.addr == 4'h9 && !write_protect_out &&
      since_ff < 16'(REARM_CYC - 2) |=> !write_protect_out;
  endproperty
  a_lock: assert property (p_lock) else $error("early re-arm");
  property p_irq;
    interrupt_out |-> periodic_event_flag_out || alarm_event_flag_out;
  endproperty
  a_irq: assert property (p_irq) else $error("stray interrupt");
  property p_alarm;
    alarm_match_in |=> alarm_event_flag_out;
  endproperty
  a_alarm: assert property (p_alarm) else $error("alarm flag lost");
  c_clear: cover property ($fell(write_protect_out));
  c_irq: cover property ($rose(interrupt_out));
  c_bank: cover property (write_protect_out && req_in.wr && req_in.addr == 4'ha);
endmodule // rwp_chk

bind rwp_top rwp_chk #(.REARM_CYC(REARM_CYC)) u_chk (
  .clk_in(clk_in), .sys_rst_in(sys_rst_in), .req_in(req_in),
  .chip_select_high_in(chip_select_high_in), .alarm_match_in(alarm_match_in),
  .rdata_out(rdata_out), .write_protect_out(write_protect_out),
  .periodic_event_flag_out(periodic_event_flag_out),
  .alarm_event_flag_out(alarm_event_flag_out), .bank_out(bank_out),
  .interrupt_out(interrupt_out));

// ==== rwp_host.sv ====
// Host model that issues one nibble access per call
`timescale 1ns/1ps
module rwp_host (
  input  wire logic         clk_in, // Clock
  output rwp_pkg::rwp_req_s req_out // Access
);
  import rwp_pkg::*;
  initial req_out = '0;
  // Host does not clear protection first; writes issued while protected are ignored except those to the bank select and protect bits
  // No half-minute round is ever raised by this host
  task automatic acc(input logic w, r, input logic [3:0] a, d);
    @(negedge clk_in);
    req_out = '{wr: w, rd: r, addr: a, data: d};
    @(negedge clk_in);
    req_out = '{wr: 1'b0, rd: 1'b0, addr: ~a, data: ~d};
  endtask
endmodule // rwp_host

// ==== rwp_tb.sv ====
// Self-checking bench for the write-protect and flag block
`timescale 1ns/1ps
module tb;
  import rwp_pkg::*;
  logic clk_in = 1'b0, sys_rst_in = 1'b1, cs_in = 1'b0, sec_in = 1'b0;
  logic alm_in = 1'b0, tick_on = 1'b0, rd_d = 1'b0;
  logic wp, pf, af, bank, irq;
  logic [7:0] tick_in = 8'h0;
  logic [3:0] rdata;
  logic [3:0] mem [8];
  logic [3:0] exp_q [$];
  rwp_req_s req;
  int failures = 0, comparisons = 0, cyc = 0;
  always #20 clk_in = ~clk_in;
  rwp_host u_host (.clk_in(clk_in), .req_out(req));
  rwp_top #(.CSUP_CYC(20), .HOLD_CYC(30), .REARM_CYC(10)) u_dut (
    .clk_in(clk_in), .sys_rst_in(sys_rst_in), .req_in(req),
    .chip_select_high_in(cs_in), .sec_carry_in(sec_in),
    .period_tick_in(tick_in), .alarm_match_in(alm_in), .rdata_out(rdata),
    .write_protect_out(wp), .periodic_event_flag_out(pf),
    .alarm_event_flag_out(af), .bank_out(bank), .interrupt_out(irq));
  task automatic check(input string what, input logic [3:0] seen, exp);
    comparisons++;
    if (seen !== exp) begin
      failures++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic wrap_up();
    $display("Counts: %0d comparisons, %0d failures", comparisons, failures);
    if (failures == 0 && comparisons > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic cycles(input int n);
    repeat (n) @(negedge clk_in);
  endtask
  task automatic rd(input logic [3:0] a, exp);
    exp_q.push_back(exp);
    u_host.acc(1'b0, 1'b1, a, 4'h0);
  endtask
  task automatic wr(input logic [3:0] a, d);
    u_host.acc(1'b1, 1'b0, a, d);
  endtask
  task automatic pulse(input logic sec, alm);
    @(negedge clk_in);
    sec_in = sec;
    alm_in = alm;
    @(negedge clk_in);
    sec_in = 1'b0;
    alm_in = 1'b0;
  endtask
  // Select high past the settle time, clear, then wait out the hold
  task automatic unprotect();
    int n;
    cs_in = 1'b1;
    cycles(30);
    wr(4'h9, 4'he);
    cycles(20);
    check("wp held", {3'h0, wp}, 4'h1);
    n = 0;
    while (wp !== 1'b0 && n < 40) begin
      @(negedge clk_in);
      n++;
    end
    check("wp cleared", {3'h0, wp}, 4'h0);
  endtask
  // Read results land one cycle after the request
  always @(posedge clk_in) rd_d <= req.rd;
  always @(negedge clk_in) begin
    if (rd_d) check("rdata", rdata, exp_q.pop_front());
    if (tick_on) tick_in = 8'($urandom());
    cyc++;
    if (cyc == 3000) begin
      failures++;
      wrap_up();
    end
  end
  initial begin
    void'($urandom(32'h1391));
    cycles(8);
    sys_rst_in = 1'b0;
    check("wp reset", {3'h0, wp}, 4'h1);
    wr(4'ha, 4'h1);
    check("bank", {3'h0, bank}, 4'h1);
    wr(4'h8, 4'hf);
    wr(4'h3, 4'h9);
    wr(4'h9, 4'h0);
    check("wp select low", {3'h0, wp}, 4'h1);
    rd(4'h8, 4'h0);
    rd(4'h3, 4'h0);
    $display("Test protected writes done");
    unprotect();
    wr(4'h9, 4'h1);
    check("wp lockout", {3'h0, wp}, 4'h0);
    cycles(12);
    wr(4'h9, 4'h1);
    check("wp rearm", {3'h0, wp}, 4'h1);
    unprotect();
    $display("Test protect sequencing done");
    for (int i = 0; i < 8; i++) begin
      mem[i] = 4'($urandom());
      wr(4'(i), mem[i]);
    end
    for (int i = 0; i < 8; i++) rd(4'(i), mem[i]);
    for (int i = 12; i < 16; i++) begin
      wr(4'(i), 4'hf);
      rd(4'(i), 4'h0);
    end
    $display("Test storage done");
    wr(4'h8, 4'hc);
    rd(4'h8, 4'hc);
    pulse(1'b0, 1'b1);
    check("alarm flag", {3'h0, af}, 4'h1);
    check("irq on", {3'h0, irq}, 4'h1);
    rd(4'h9, 4'h4);
    rd(4'h9, 4'h0);
    check("irq off", {3'h0, irq}, 4'h0);
    wr(4'hb, 4'h5);
    tick_on = 1'b1;
    pulse(1'b1, 1'b0);
    check("carry flag", {3'h0, pf}, 4'h1);
    rd(4'h9, 4'ha);
    rd(4'h9, 4'h0);
    wr(4'h8, 4'hd);
    pulse(1'b1, 1'b0);
    check("masked flag", {3'h0, pf}, 4'h1);
    check("masked irq", {3'h0, irq}, 4'h0);
    wr(4'h8, 4'h0);
    pulse(1'b0, 1'b1);
    check("pulse high", {3'h0, af}, 4'h1);
    cycles(1);
    check("pulse low", {3'h0, af}, 4'h0);
    // Plain interval tick on select 2 in pulse mode
    tick_on = 1'b0;
    wr(4'hb, 4'h2);
    tick_in = 8'h04;
    cycles(1);
    tick_in = 8'h00;
    check("tick flag", {3'h0, pf}, 4'h1);
    check("tick irq", {3'h0, irq}, 4'h1);
    cycles(1);
    check("tick flag low", {3'h0, pf}, 4'h0);
    $display("Test flags done");
    wr(4'ha, 4'h7);
    rd(4'ha, 4'h1);
    rd(4'ha, 4'h1);
    $display("Test test bits done");
    wrap_up();
  end
endmodule // tb
